// File: shared/tvsp_pkg.sv
// shared constants, carrier types and position arithmetic for the tdm port
package tvsp_pkg;

    localparam int SLOT_BITS = 8;
    localparam int SLOT_MAX = 128;
    localparam int SLOT_AW = 7;
    localparam int BIT_AW = 3;
    localparam int POS_W = SLOT_AW + BIT_AW;

    // pin slots of the five shared general purpose pins
    localparam int PIN_DOUT = 0;
    localparam int PIN_DIN = 1;
    localparam int PIN_FM = 2;
    localparam int PIN_CLK = 3;
    localparam int PIN_TEN = 4;
    localparam int PIN_N = 5;

    localparam int SYNC_STAGES = 2;
    // transmit position runs this many bits ahead of the sampled position
    localparam logic [3:0] TX_LEAD = 4'h3;
    localparam logic [3:0] RD_AHEAD = 4'h1;

    localparam real SYS_PERIOD_NS = 5.0;
    localparam real MAX_RATE_MBPS = 8.192;
    // shortest bit period in system clocks, rounded down
    localparam int MIN_BIT_CYC =
        int'($floor(1000.0 / (MAX_RATE_MBPS * SYS_PERIOD_NS)));

    localparam logic [SLOT_AW-1:0] SLOT_LAST_RST = 7'h00;
    localparam logic [BIT_AW-1:0] BIT_LAST = 3'h7;

    typedef struct packed {
        logic master;
        logic fm_high;
        logic enable;
        logic [SLOT_AW-1:0] slot_last;
    } tvsp_cfg_type;

    typedef struct packed {
        logic tx_en;
        logic rx_en;
        logic [SLOT_BITS-1:0] tx_byte;
    } tvsp_entry_type;

    typedef struct packed {
        logic [SLOT_AW-1:0] slot;
        logic [SLOT_BITS-1:0] data;
    } tvsp_rx_type;

    typedef struct packed {
        logic [SLOT_AW-1:0] slot;
        logic [BIT_AW-1:0] bitn;
    } tvsp_pos_type;

    // advance a frame position by k bits, wrapping at the frame length
    function automatic tvsp_pos_type tvsp_pos_add(
        input tvsp_pos_type pos,
        input logic [3:0] k,
        input logic [SLOT_AW-1:0] last
    );
        logic [POS_W:0] sum;
        logic [POS_W:0] len;
        sum = {1'b0, pos} + {7'h00, k};
        len = {1'b0, last, BIT_LAST};
        if (sum > len) begin
            sum = sum - len - 11'h001;
        end
        return tvsp_pos_type'(sum[POS_W-1:0]);
    endfunction : tvsp_pos_add

endpackage : tvsp_pkg

// File: logic/tvsp_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module tvsp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule : tvsp_sync
`default_nettype wire

// File: logic/tvsp_slot_table.sv
// per-slot table: written on the system clock, read on the bit clock
`timescale 1ns/10ps
`default_nettype none
module tvsp_slot_table #(
    parameter int DEPTH = tvsp_pkg::SLOT_MAX,
    parameter int AW = tvsp_pkg::SLOT_AW
) (
    input wire logic wr_clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire tvsp_pkg::tvsp_entry_type wr_data,
    input wire logic rd_clk,
    input wire logic arst_n,
    input wire logic [AW-1:0] rd_addr_a,
    input wire logic [AW-1:0] rd_addr_b,
    output tvsp_pkg::tvsp_entry_type rd_data_a,
    output tvsp_pkg::tvsp_entry_type rd_data_b
);

    tvsp_pkg::tvsp_entry_type mem [DEPTH];
    tvsp_pkg::tvsp_entry_type rda_q;
    tvsp_pkg::tvsp_entry_type rdb_q;

    always_ff @(posedge wr_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge rd_clk or negedge arst_n) begin
        if (!arst_n) begin
            rda_q <= '0;
            rdb_q <= '0;
        end else begin
            rda_q <= mem[rd_addr_a];
            rdb_q <= mem[rd_addr_b];
        end
    end

    assign rd_data_a = rda_q;
    assign rd_data_b = rdb_q;

endmodule : tvsp_slot_table
`default_nettype wire

// File: logic/tvsp_top.sv
// tdm voice serial port: slot timing on the bit clock, pin muxing on sys_clk
`timescale 1ns/10ps
`default_nettype none
module tvsp_top (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic slot_bit_clock,
    input wire logic port_enable,
    input wire logic master_mode,
    input wire logic frame_active_high,
    input wire logic [tvsp_pkg::SLOT_AW-1:0] slot_last,
    input wire logic [tvsp_pkg::PIN_N-1:0] alt_sel,
    input wire logic tbl_wr,
    input wire logic [tvsp_pkg::SLOT_AW-1:0] tbl_addr,
    input wire tvsp_pkg::tvsp_entry_type tbl_data,
    input wire logic [tvsp_pkg::PIN_N-1:0] gpio_out,
    input wire logic [tvsp_pkg::PIN_N-1:0] gpio_oe,
    output logic [tvsp_pkg::PIN_N-1:0] gpio_in,
    input wire logic [tvsp_pkg::PIN_N-1:0] general_purpose_pin_in,
    output logic [tvsp_pkg::PIN_N-1:0] general_purpose_pin_out,
    output logic [tvsp_pkg::PIN_N-1:0] general_purpose_pin_oe,
    output logic rx_valid,
    output tvsp_pkg::tvsp_rx_type rx_word
);

    ////////////////////////////////////////////////////////////////////////
    // configuration captured on sys_clk, then carried to the bit clock

    tvsp_pkg::tvsp_cfg_type cfg_q;
    tvsp_pkg::tvsp_cfg_type cfg_d;
    tvsp_pkg::tvsp_cfg_type cfg_l;

    always_comb begin
        cfg_d.master = master_mode;
        cfg_d.fm_high = frame_active_high;
        // the port works only with its pins up to the clock pin switched over; the enable pin is not required
        cfg_d.enable = port_enable & (&alt_sel[tvsp_pkg::PIN_CLK:0]);
        cfg_d.slot_last = slot_last;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    tvsp_sync #(.WIDTH($bits(tvsp_pkg::tvsp_cfg_type))) u_cfg_sync (
        .clk(slot_bit_clock),
        .arst_n(arst_n),
        .async_in(cfg_q),
        .sync_out(cfg_l)
    );

    ////////////////////////////////////////////////////////////////////////
    // bit clock domain: sampling, frame detection, slot counting

    logic [1:0] lin_s;
    logic din_s;
    logic fm_s;

    tvsp_sync #(.WIDTH(2)) u_lin_sync (
        .clk(slot_bit_clock),
        .arst_n(arst_n),
        .async_in({general_purpose_pin_in[tvsp_pkg::PIN_FM],
                   general_purpose_pin_in[tvsp_pkg::PIN_DIN]}),
        .sync_out(lin_s)
    );

    assign din_s = lin_s[0];
    assign fm_s = lin_s[1];

    tvsp_pkg::tvsp_pos_type pos_q;
    tvsp_pkg::tvsp_pos_type rx_cur;
    tvsp_pkg::tvsp_pos_type tx_pos;
    tvsp_pkg::tvsp_pos_type rd_pos_a;
    tvsp_pkg::tvsp_pos_type rd_pos_b;
    tvsp_pkg::tvsp_entry_type ent_a;
    tvsp_pkg::tvsp_entry_type ent_b;
    tvsp_pkg::tvsp_rx_type rx_out_q;
    tvsp_pkg::tvsp_rx_type rx_out_d;
    logic fm_prev_q;
    logic fm_act;
    logic start;
    logic [7:0] rx_sh_q;
    logic [7:0] rx_sh_d;
    logic rx_tgl_q;
    logic rx_tgl_d;
    logic tx_drv_q;
    logic tx_drv_d;
    logic tx_bit_q;
    logic tx_bit_d;
    logic fm_drv_q;
    logic fm_drv_d;
    logic fm_lvl_q;
    logic fm_lvl_d;

    always_comb begin
        fm_act = fm_s ^ ~cfg_l.fm_high;
        start = fm_act & ~fm_prev_q;
        // position of the bit now leaving the synchroniser
        rx_cur = start ? '0 : tvsp_pkg::tvsp_pos_add(pos_q, 4'h1,
            cfg_l.slot_last);
        tx_pos = tvsp_pkg::tvsp_pos_add(rx_cur, tvsp_pkg::TX_LEAD,
            cfg_l.slot_last);
        // table reads are registered, so fetch one bit ahead
        rd_pos_a = tvsp_pkg::tvsp_pos_add(tx_pos, tvsp_pkg::RD_AHEAD,
            cfg_l.slot_last);
        rd_pos_b = tvsp_pkg::tvsp_pos_add(rx_cur, tvsp_pkg::RD_AHEAD,
            cfg_l.slot_last);

        rx_sh_d = rx_sh_q;
        rx_out_d = rx_out_q;
        rx_tgl_d = rx_tgl_q;
        if (cfg_l.enable && ent_b.rx_en) begin
            rx_sh_d = {rx_sh_q[6:0], din_s};
            if (rx_cur.bitn == tvsp_pkg::BIT_LAST) begin
                rx_out_d.slot = rx_cur.slot;
                rx_out_d.data = rx_sh_d;
                rx_tgl_d = ~rx_tgl_q;
            end
        end

        tx_drv_d = cfg_l.enable & ent_a.tx_en;
        tx_bit_d = ent_a.tx_byte[3'h7 - tx_pos.bitn];
        fm_drv_d = cfg_l.enable & cfg_l.master;
        fm_lvl_d = (tx_pos == '0) ? cfg_l.fm_high : ~cfg_l.fm_high;
    end

    always_ff @(posedge slot_bit_clock or negedge arst_n) begin
        if (!arst_n) begin
            pos_q <= '0;
            // seen as active so that leaving reset is no frame start
            fm_prev_q <= 1'b1;
            rx_sh_q <= '0;
            rx_out_q <= '0;
            rx_tgl_q <= 1'b0;
            tx_drv_q <= 1'b0;
            tx_bit_q <= 1'b0;
            fm_drv_q <= 1'b0;
            fm_lvl_q <= 1'b0;
        end else begin
            pos_q <= rx_cur;
            fm_prev_q <= fm_act;
            rx_sh_q <= rx_sh_d;
            rx_out_q <= rx_out_d;
            rx_tgl_q <= rx_tgl_d;
            tx_drv_q <= tx_drv_d;
            tx_bit_q <= tx_bit_d;
            fm_drv_q <= fm_drv_d;
            fm_lvl_q <= fm_lvl_d;
        end
    end

    tvsp_slot_table u_table (
        .wr_clk(sys_clk),
        .wr_en(tbl_wr),
        .wr_addr(tbl_addr),
        .wr_data(tbl_data),
        .rd_clk(slot_bit_clock),
        .arst_n(arst_n),
        .rd_addr_a(rd_pos_a.slot),
        .rd_addr_b(rd_pos_b.slot),
        .rd_data_a(ent_a),
        .rd_data_b(ent_b)
    );

    start_clear_a: assert property (
        @(posedge slot_bit_clock) disable iff (!arst_n)
        start |=> pos_q == '0)
        else $error("frame start did not clear the counters");

    slot_advance_a: assert property (
        @(posedge slot_bit_clock) disable iff (!arst_n)
        !start && pos_q.bitn == 3'h7 && pos_q.slot < cfg_l.slot_last
        && $stable(cfg_l) |=> pos_q.bitn == 3'h0
        && pos_q.slot == $past(pos_q.slot) + 7'h01)
        else $error("slot count did not advance after eight bits");

    frame_wrap_a: assert property (
        @(posedge slot_bit_clock) disable iff (!arst_n)
        pos_q.slot == cfg_l.slot_last && pos_q.bitn == 3'h7
        ##1 $stable(cfg_l) |-> pos_q == '0)
        else $error("frame did not wrap after its last slot");

    tx_gate_a: assert property (
        @(posedge slot_bit_clock) disable iff (!arst_n)
        !cfg_l.enable || !ent_a.tx_en |=> !tx_drv_q)
        else $error("data output driven outside a transmit slot");

    rx_ignore_a: assert property (
        @(posedge slot_bit_clock) disable iff (!arst_n)
        !(cfg_l.enable && ent_b.rx_en) |=> $stable(rx_sh_q)
        && $stable(rx_tgl_q))
        else $error("input captured outside a receive slot");

    fm_slave_a: assert property (
        @(posedge slot_bit_clock) disable iff (!arst_n)
        !cfg_l.master |=> !fm_drv_q)
        else $error("frame marker driven in slave mode");

    fm_pulse_a: assert property (
        @(posedge slot_bit_clock) disable iff (!arst_n)
        fm_drv_q && fm_lvl_q == cfg_l.fm_high && $stable(cfg_l)
        |=> fm_lvl_q != cfg_l.fm_high)
        else $error("frame marker active for more than one bit");

    ////////////////////////////////////////////////////////////////////////
    // system clock domain: pin muxing and received slot hand-off

    logic [3:0] lnk_s;
    logic rx_tgl_s;
    logic rx_tgl_prev_q;
    logic [tvsp_pkg::PIN_N-1:0] gpin_s;

    tvsp_sync #(.WIDTH(5)) u_lnk_sync (
        .clk(sys_clk),
        .arst_n(arst_n),
        .async_in({rx_tgl_q, fm_lvl_q, fm_drv_q, tx_bit_q, tx_drv_q}),
        .sync_out({rx_tgl_s, lnk_s})
    );

    tvsp_sync #(.WIDTH(tvsp_pkg::PIN_N)) u_gpin_sync (
        .clk(sys_clk),
        .arst_n(arst_n),
        .async_in(general_purpose_pin_in),
        .sync_out(gpin_s)
    );

    logic [tvsp_pkg::PIN_N-1:0] pin_out_q;
    logic [tvsp_pkg::PIN_N-1:0] pin_out_d;
    logic [tvsp_pkg::PIN_N-1:0] pin_oe_q;
    logic [tvsp_pkg::PIN_N-1:0] pin_oe_d;
    logic [tvsp_pkg::PIN_N-1:0] port_out;
    logic [tvsp_pkg::PIN_N-1:0] port_oe;
    logic [tvsp_pkg::PIN_N-1:0] gpin_q;
    logic rx_valid_q;
    logic rx_valid_d;
    tvsp_pkg::tvsp_rx_type rx_word_q;
    tvsp_pkg::tvsp_rx_type rx_word_d;

    always_comb begin
        port_out = '0;
        port_oe = '0;
        port_out[tvsp_pkg::PIN_DOUT] = lnk_s[1];
        port_oe[tvsp_pkg::PIN_DOUT] = lnk_s[0];
        port_out[tvsp_pkg::PIN_FM] = lnk_s[3];
        port_oe[tvsp_pkg::PIN_FM] = lnk_s[2];
        // same source as the data enable, so both move together
        port_out[tvsp_pkg::PIN_TEN] = ~lnk_s[0];
        port_oe[tvsp_pkg::PIN_TEN] = 1'b1;
        for (int i = 0; i < tvsp_pkg::PIN_N; i++) begin
            pin_out_d[i] = alt_sel[i] ? port_out[i] : gpio_out[i];
            pin_oe_d[i] = alt_sel[i] ? port_oe[i] : gpio_oe[i];
        end
        rx_valid_d = rx_tgl_s ^ rx_tgl_prev_q;
        // the word is held for a whole slot, long past the toggle sync
        rx_word_d = rx_valid_d ? rx_out_q : rx_word_q;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_out_q <= '0;
            pin_oe_q <= '0;
            gpin_q <= '0;
            rx_tgl_prev_q <= 1'b0;
            rx_valid_q <= 1'b0;
            rx_word_q <= '0;
        end else begin
            pin_out_q <= pin_out_d;
            pin_oe_q <= pin_oe_d;
            gpin_q <= gpin_s;
            rx_tgl_prev_q <= rx_tgl_s;
            rx_valid_q <= rx_valid_d;
            rx_word_q <= rx_word_d;
        end
    end

    assign general_purpose_pin_out = pin_out_q;
    assign general_purpose_pin_oe = pin_oe_q;
    assign gpio_in = gpin_q;
    assign rx_valid = rx_valid_q;
    assign rx_word = rx_word_q;

    buf_enable_a: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        $past(arst_n) && $past(alt_sel[tvsp_pkg::PIN_DOUT])
        && $past(alt_sel[tvsp_pkg::PIN_TEN])
        |-> pin_oe_q[tvsp_pkg::PIN_DOUT] == !pin_out_q[tvsp_pkg::PIN_TEN])
        else $error("buffer enable disagrees with data output drive");

    gpio_pass_a: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !alt_sel[tvsp_pkg::PIN_FM] ##1 1'b1 |->
        pin_out_q[tvsp_pkg::PIN_FM] == $past(gpio_out[tvsp_pkg::PIN_FM])
        && pin_oe_q[tvsp_pkg::PIN_FM] == $past(gpio_oe[tvsp_pkg::PIN_FM]))
        else $error("pin not following general purpose function");

    rx_pulse_a: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        rx_valid_q |=> !rx_valid_q [*2])
        else $error("received slot strobe longer than one cycle");

endmodule : tvsp_top
`default_nettype wire

// File: bench/tvsp_codec_model.sv
// far side codec: bit clock, frame marker as slave, data in, tx capture
`timescale 1ns/10ps
`default_nettype none
module tvsp_codec_model (
    input wire logic run,
    input wire logic master_mode,
    input wire logic frame_active_high,
    input wire logic [6:0] slot_last,
    input wire logic fm_line,
    input wire logic dout_line,
    input wire logic ten_n_line,
    output logic bit_clk,
    output logic din,
    output logic fm_out,
    output logic fm_drive,
    output logic rep_stb,
    output logic [6:0] rep_slot,
    output logic [7:0] rep_byte,
    output logic [3:0] rep_n
);
    logic [9:0] pos;
    logic [9:0] npos;
    logic [7:0] sh;
    logic [7:0] tx_b;
    logic fm_prev;
    logic act;
    initial begin
        {bit_clk, din, fm_out, rep_stb, fm_prev} = 5'h00;
        {pos, sh, rep_slot, rep_byte, rep_n} = 37'h0;
    end
    // clock stands low while the link is idle
    always begin
        #32;
        bit_clk = run ? ~bit_clk : 1'b0;
    end
    assign fm_drive = run & ~master_mode;
    // sample on rising edge, count positions from the marker
    always @(posedge bit_clk) begin
        act = (fm_line == frame_active_high);
        if (act && !fm_prev) begin
            pos = 10'h000;
        end else begin
            pos = (pos >= {slot_last, 3'h7}) ? 10'h000 : pos + 10'h001;
        end
        fm_prev = act;
        sh = {sh[6:0], dout_line};
        rep_n = (pos[2:0] == 3'h0 ? 4'h0 : rep_n) + {3'h0, ~ten_n_line};
        rep_stb = (pos[2:0] == 3'h7);
        rep_slot = pos[9:3];
        rep_byte = sh;
    end
    // launch the next bit on the falling edge, msb first
    always @(negedge bit_clk) begin
        npos = (pos >= {slot_last, 3'h7}) ? 10'h000 : pos + 10'h001;
        tx_b = 8'hc3 ^ {1'b0, npos[9:3]};
        fm_out = (npos == 10'h000) ~^ frame_active_high;
        din = tx_b[3'h7 - npos[2:0]];
    end
endmodule : tvsp_codec_model
`default_nettype wire

// File: bench/tb_tvsp_top.sv
// self-checking bench for the tdm voice serial port
`timescale 1ns/10ps
`default_nettype none
module tb_tvsp_top;
    typedef struct packed {
        logic master;
        logic pol;
        logic [6:0] last;
        logic [7:0] n_rx;
    } tvsp_row_type;
    localparam tvsp_row_type ROWS [4] = '{
        '{1'b0, 1'b1, 7'h03, 8'h02}, '{1'b0, 1'b0, 7'h00, 8'h01},
        '{1'b1, 1'b1, 7'h05, 8'h03}, '{1'b1, 1'b0, 7'h7f, 8'h40}};
    logic sys_clk, arst_n, port_enable, master_mode, frame_active_high;
    logic [6:0] slot_last, tbl_addr, rep_slot;
    logic [4:0] alt_sel, gpio_out, gpio_oe, gpio_in, pull_v;
    logic [4:0] pin_out, pin_oe, pin_lvl, ext;
    logic tbl_wr, rx_valid, run, bit_clk, din, fm_out, fm_drive, rep_stb;
    logic tog = 1'b0;
    logic mon_q = 1'b0;
    logic chk_on = 1'b0;
    logic [7:0] rep_byte;
    logic [3:0] rep_n;
    tvsp_pkg::tvsp_entry_type tbl_data, e_tx, e_rx;
    tvsp_pkg::tvsp_rx_type rx_word;
    tvsp_pkg::tvsp_rx_type q[$];
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    // undriven data out line toggles every cycle
    assign ext = {pull_v[4], run ? bit_clk : pull_v[3],
        fm_drive ? fm_out : pull_v[2], run ? din : pull_v[1], tog};
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext);
    tvsp_top dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .slot_bit_clock(bit_clk), .port_enable(port_enable),
        .master_mode(master_mode), .frame_active_high(frame_active_high),
        .slot_last(slot_last), .alt_sel(alt_sel), .tbl_wr(tbl_wr),
        .tbl_addr(tbl_addr), .tbl_data(tbl_data), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .gpio_in(gpio_in),
        .general_purpose_pin_in(pin_lvl), .general_purpose_pin_out(pin_out),
        .general_purpose_pin_oe(pin_oe), .rx_valid(rx_valid),
        .rx_word(rx_word));
    tvsp_codec_model partner (.run(run), .master_mode(master_mode),
        .frame_active_high(frame_active_high), .slot_last(slot_last),
        .fm_line(pin_lvl[2]), .dout_line(pin_lvl[0]),
        .ten_n_line(pin_lvl[4]), .bit_clk(bit_clk), .din(din),
        .fm_out(fm_out), .fm_drive(fm_drive), .rep_stb(rep_stb),
        .rep_slot(rep_slot), .rep_byte(rep_byte), .rep_n(rep_n));
    ////////////////////////////////////////////////////////////////////////
    function automatic tvsp_pkg::tvsp_entry_type ent(input logic [6:0] s);
        tvsp_pkg::tvsp_entry_type e;
        e.tx_en = (s[1:0] == 2'h0) || (s[1:0] == 2'h3);
        e.rx_en = ~s[0];
        e.tx_byte = 8'h5a ^ {s, 1'b0};
        return e;
    endfunction : ent
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out;
        if (n_fail == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic run_row(input tvsp_row_type r);
        int flen;
        flen = (int'(r.last) + 1) * 8;
        @(posedge sys_clk);
        master_mode <= r.master;
        frame_active_high <= r.pol;
        slot_last <= r.last;
        alt_sel <= 5'h1f;
        run <= 1'b1;
        port_enable <= 1'b1;
        repeat (flen + 24) @(posedge bit_clk);
        chk_on = 1'b1;
        @(negedge sys_clk);
        q.delete();
        repeat (flen + 16) @(posedge bit_clk);
        chk_on = 1'b0;
        @(negedge sys_clk);
        check(16'(q.size() >= int'(r.n_rx)), 16'h1);
        foreach (q[i]) begin
            e_rx = ent(q[i].slot);
            check({7'h0, e_rx.rx_en, q[i].data}, 16'(9'h1c3 ^ q[i].slot));
        end
        @(posedge sys_clk);
        port_enable <= 1'b0;
        repeat (8) @(posedge bit_clk);
        @(negedge sys_clk);
        q.delete();
        repeat (16) @(posedge bit_clk);
        @(negedge sys_clk);
        check(16'({pin_oe[0], q.size() == 0}), 16'h1);
    endtask : run_row
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        tog <= ~tog;
        mon_q <= arst_n & alt_sel[0] & alt_sel[4];
        cyc <= cyc + 1;
        if (rx_valid === 1'b1) begin
            q.push_back(rx_word);
        end
        if (mon_q && arst_n && alt_sel[0] && alt_sel[4]) begin
            check(16'({pin_oe[4], pin_out[4] ^ pin_oe[0]}), 16'h3);
        end
        if (cyc == 60000) begin
            n_fail++;
            close_out();
        end
    end
    // per-slot transmit report from the codec
    always @(negedge bit_clk) begin
        if (chk_on && rep_stb) begin
            e_tx = ent(rep_slot);
            check({rep_n, rep_byte & {8{e_tx.tx_en}}}, 16'({e_tx.tx_en, 3'h0,
                e_tx.tx_byte & {8{e_tx.tx_en}}}));
        end
    end
    initial begin
        {arst_n, port_enable, master_mode, frame_active_high} = 4'h0;
        {tbl_wr, run, slot_last, tbl_addr, tbl_data} = 26'h0;
        {alt_sel, gpio_out, gpio_oe, pull_v} = 20'h0;
        repeat (5) @(posedge sys_clk);
        check(16'({pin_oe, gpio_in, rx_valid}), 16'h0);
        arst_n <= 1'b1;
        for (int s = 0; s < 128; s++) begin
            @(posedge sys_clk);
            tbl_wr <= 1'b1;
            tbl_addr <= 7'(s);
            tbl_data <= ent(7'(s));
        end
        @(posedge sys_clk);
        tbl_wr <= 1'b0;
        foreach (ROWS[i]) begin
            run_row(ROWS[i]);
        end
        // general purpose mode with the link idle
        @(posedge sys_clk);
        run <= 1'b0;
        alt_sel <= 5'h00;
        gpio_out <= 5'h15;
        gpio_oe <= 5'h0f;
        pull_v <= 5'h1b;
        repeat (6) @(posedge sys_clk);
        check({1'b0, pin_oe, pin_out & 5'h0f, gpio_in}, 16'h3cb5);
        alt_sel <= 5'h10;
        gpio_oe <= 5'h00;
        repeat (6) @(posedge sys_clk);
        check(16'({pin_oe, pin_out[4], gpio_in[4:1]}), 16'h21d);
        // reset in the middle of traffic
        run <= 1'b1;
        alt_sel <= 5'h1f;
        port_enable <= 1'b1;
        repeat (40) @(posedge bit_clk);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (30) @(posedge sys_clk);
        check(16'({pin_oe, gpio_in, rx_valid}), 16'h0);
        arst_n <= 1'b1;
        run_row(ROWS[0]);
        close_out();
    end
endmodule : tb_tvsp_top
`default_nettype wire
